// file: verilog/interrupt_flag_status_bank.sv
// Our own choices: the AXI4-Lite slave port and the address map.
`include "flag_bank_defines.svh"

module interrupt_flag_status_bank #(
  parameter bit CAN_PRESENT = 1'b1
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic pwm_a_fault_in,
  input wire logic calendar_clock_in,
  input wire logic dma_chan5_done_in,
  input wire logic encoder_a_event_in,
  input wire logic pwm_a_event_in,
  input wire logic audio_left_in,
  input wire logic audio_right_in,
  input wire logic encoder_b_event_in,
  input wire logic pwm_b_fault_in,
  input wire logic pwm_b_event_in,
  input wire logic can_transmit_request_in,
  input wire logic dma_chan7_done_in,
  input wire logic dma_chan6_done_in,
  input wire logic checksum_unit_in,
  input wire logic serial_b_error_in,
  input wire logic serial_a_error_in,
  input wire logic [`ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [`ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output flag_bank_pkg::flag_word_t interrupt_flags_two_out,
  output flag_bank_pkg::flag_word_t interrupt_flags_three_out,
  output logic irq_out
);
  import flag_bank_pkg::*;

  flag_word_t flags_two_q;
  flag_word_t flags_three_q;
  flag_word_t flags_two_d;
  flag_word_t flags_three_d;
  flag_word_t mask_two_q;
  flag_word_t mask_three_q;
  flag_word_t req_two;
  flag_word_t req_three;
  logic [`ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_held_q;
  logic w_held_q;
  logic wr_fire;
  logic [`ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  flag_word_t wr_mask;
  flag_word_t wr_val;

  // Sources map onto their bit positions; unused positions stay zero.
  always_comb begin
    req_two = `FLAGS_RESET;
    req_three = `FLAGS_RESET;
    req_two[`PWM_A_FAULT_BIT] = pwm_a_fault_in;
    req_two[`CALENDAR_CLOCK_BIT] = calendar_clock_in;
    req_two[`DMA_CHAN5_DONE_BIT] = dma_chan5_done_in;
    req_two[`ENCODER_A_EVENT_BIT] = encoder_a_event_in;
    req_two[`PWM_A_EVENT_BIT] = pwm_a_event_in;
    req_three[`AUDIO_LEFT_BIT] = audio_left_in;
    req_three[`AUDIO_RIGHT_BIT] = audio_right_in;
    req_three[`ENCODER_B_EVENT_BIT] = encoder_b_event_in;
    req_three[`PWM_B_FAULT_BIT] = pwm_b_fault_in;
    req_three[`PWM_B_EVENT_BIT] = pwm_b_event_in;
    req_three[`CAN_TX_REQUEST_BIT] = can_transmit_request_in &
      CAN_PRESENT;
    req_three[`DMA_CHAN7_DONE_BIT] = dma_chan7_done_in;
    req_three[`DMA_CHAN6_DONE_BIT] = dma_chan6_done_in;
    req_three[`CHECKSUM_UNIT_BIT] = checksum_unit_in;
    req_three[`SERIAL_B_ERROR_BIT] = serial_b_error_in;
    req_three[`SERIAL_A_ERROR_BIT] = serial_a_error_in;
  end

  // Address and data may arrive in either order; each is held until both.
  assign wr_fire = (aw_held_q | (s_axi_awvalid_in & s_axi_awready_out)) &
    (w_held_q | (s_axi_wvalid_in & s_axi_wready_out)) & ~s_axi_bvalid_out;
  assign wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr_in;
  assign wr_data = w_held_q ? wdata_q : s_axi_wdata_in;
  assign wr_strb = w_held_q ? wstrb_q : s_axi_wstrb_in;
  assign wr_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign wr_val = wr_data[15:0];

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata_in;
        wstrb_q <= s_axi_wstrb_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
    end else begin
      s_axi_awready_out <= ~aw_held_q & ~wr_fire & ~s_axi_bvalid_out &
        ~(s_axi_awvalid_in & s_axi_awready_out);
      s_axi_wready_out <= ~w_held_q & ~wr_fire & ~s_axi_bvalid_out &
        ~(s_axi_wvalid_in & s_axi_wready_out);
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_out <= 1'b1;
      case (wr_addr)
        `FLAGS_TWO_ADDR, `FLAGS_THREE_ADDR, `FLAGS_MASK_TWO_ADDR,
        `FLAGS_MASK_THREE_ADDR: begin
          s_axi_bresp_out <= `RESP_OKAY;
        end
        default: begin
          s_axi_bresp_out <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // A request in the same cycle as a software zero wins, so no event is lost.
  always_comb begin
    flags_two_d = flags_two_q;
    flags_three_d = flags_three_q;
    if (wr_fire && wr_addr == `FLAGS_TWO_ADDR) begin
      flags_two_d = (flags_two_d & ~wr_mask) | (wr_val & wr_mask);
    end
    if (wr_fire && wr_addr == `FLAGS_THREE_ADDR) begin
      flags_three_d = (flags_three_d & ~wr_mask) | (wr_val & wr_mask);
    end
    flags_two_d = (flags_two_d | req_two) & `FLAGS_TWO_IMPL;
    flags_three_d = (flags_three_d | req_three) &
      `FLAGS_THREE_IMPL;
    if (!CAN_PRESENT) begin
      flags_three_d[`CAN_TX_REQUEST_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      flags_two_q <= `FLAGS_RESET;
      flags_three_q <= `FLAGS_RESET;
    end else begin
      flags_two_q <= flags_two_d;
      flags_three_q <= flags_three_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mask_two_q <= `FLAGS_RESET;
      mask_three_q <= `FLAGS_RESET;
    end else if (wr_fire) begin
      if (wr_addr == `FLAGS_MASK_TWO_ADDR) begin
        mask_two_q <= (mask_two_q & ~wr_mask) | (wr_val & wr_mask);
      end
      if (wr_addr == `FLAGS_MASK_THREE_ADDR) begin
        mask_three_q <= (mask_three_q & ~wr_mask) | (wr_val & wr_mask);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= '0;
      s_axi_rresp_out <= `RESP_OKAY;
    end else if (s_axi_rvalid_out) begin
      s_axi_arready_out <= 1'b0;
      if (s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out <= `RESP_OKAY;
      case (s_axi_araddr_in)
        `FLAGS_TWO_ADDR: begin
          s_axi_rdata_out <= {16'h0000, flags_two_q};
        end
        `FLAGS_THREE_ADDR: begin
          s_axi_rdata_out <= {16'h0000, flags_three_q};
        end
        `FLAGS_MASK_TWO_ADDR: begin
          s_axi_rdata_out <= {16'h0000, mask_two_q};
        end
        `FLAGS_MASK_THREE_ADDR: begin
          s_axi_rdata_out <= {16'h0000, mask_three_q};
        end
        default: begin
          s_axi_rdata_out <= '0;
          s_axi_rresp_out <= `RESP_SLVERR;
        end
      endcase
    end else begin
      s_axi_arready_out <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      interrupt_flags_two_out <= `FLAGS_RESET;
      interrupt_flags_three_out <= `FLAGS_RESET;
      irq_out <= 1'b0;
    end else begin
      interrupt_flags_two_out <= flags_two_q;
      interrupt_flags_three_out <= flags_three_q;
      irq_out <= |(flags_two_q & mask_two_q) |
        |(flags_three_q & mask_three_q);
    end
  end

  pwm_fault_sets_a: assert property (@(posedge clk_in) disable iff
    (sys_rst_in) pwm_a_fault_in |=> flags_two_q[`PWM_A_FAULT_BIT])
    else $error("pwm fault a did not set its flag");
  calendar_sets_a: assert property (@(posedge clk_in) disable iff
    (sys_rst_in) calendar_clock_in |=>
    flags_two_q[`CALENDAR_CLOCK_BIT])
    else $error("calendar request did not set its flag");
  audio_left_a: assert property (@(posedge clk_in) disable iff
    (sys_rst_in) audio_left_in |=> flags_three_q[`AUDIO_LEFT_BIT])
    else $error("audio left request did not set its flag");
  audio_right_a: assert property (@(posedge clk_in) disable iff
    (sys_rst_in) audio_right_in |=> flags_three_q[`AUDIO_RIGHT_BIT])
    else $error("audio right request did not set its flag");
  encoder_b_a: assert property (@(posedge clk_in) disable iff
    (sys_rst_in) encoder_b_event_in |=>
    flags_three_q[`ENCODER_B_EVENT_BIT])
    else $error("encoder b request did not set its flag");
  pwm_fault_b_a: assert property (@(posedge clk_in) disable iff
    (sys_rst_in) pwm_b_fault_in |=> flags_three_q[`PWM_B_FAULT_BIT])
    else $error("pwm fault b did not set its flag");
  can_request_a: assert property (@(posedge clk_in) disable iff
    (sys_rst_in) can_transmit_request_in && CAN_PRESENT |=>
    flags_three_q[`CAN_TX_REQUEST_BIT])
    else $error("can request did not set its flag");
  can_absent_a: assert property (@(posedge clk_in) disable iff
    (sys_rst_in) !CAN_PRESENT |-> !flags_three_q[`CAN_TX_REQUEST_BIT])
    else $error("can flag set without a can controller");
  reserved_zero_a: assert property (@(posedge clk_in) disable iff
    (sys_rst_in) (flags_two_q & ~`FLAGS_TWO_IMPL) == 16'h0000 &&
    (flags_three_q & ~`FLAGS_THREE_IMPL) == 16'h0000)
    else $error("unimplemented flag bit is set");
  flag_sticky_a: assert property (@(posedge clk_in) disable iff
    (sys_rst_in) flags_two_q[`DMA_CHAN5_DONE_BIT] && !wr_fire |=>
    flags_two_q[`DMA_CHAN5_DONE_BIT])
    else $error("flag dropped without a software write");
  reset_clear_a: assert property (@(posedge clk_in)
    sys_rst_in |=> flags_two_q == 16'h0000 && flags_three_q == 16'h0000 &&
    !irq_out)
    else $error("flags not cleared by reset");
  flag_tracks_a: assert property (@(posedge clk_in) disable iff
    (sys_rst_in) !flags_three_q[`SERIAL_A_ERROR_BIT] && !serial_a_error_in &&
    !wr_fire |=> !flags_three_q[`SERIAL_A_ERROR_BIT])
    else $error("flag set with no request pending");
endmodule : interrupt_flag_status_bank

// file: verilog/flag_bank_defines.svh
`ifndef FLAG_BANK_DEFINES_SVH
`define FLAG_BANK_DEFINES_SVH

// Register byte addresses on the bus.
`define FLAGS_TWO_ADDR 4'h0
`define FLAGS_THREE_ADDR 4'h4
`define FLAGS_MASK_TWO_ADDR 4'h8
`define FLAGS_MASK_THREE_ADDR 4'hc
`define ADDR_W 4

// Flag positions in the second flag register.
`define PWM_A_FAULT_BIT 15
`define CALENDAR_CLOCK_BIT 14
`define DMA_CHAN5_DONE_BIT 13
`define ENCODER_A_EVENT_BIT 10
`define PWM_A_EVENT_BIT 9

// Flag positions in the third flag register.
`define AUDIO_LEFT_BIT 15
`define AUDIO_RIGHT_BIT 14
`define ENCODER_B_EVENT_BIT 11
`define PWM_B_FAULT_BIT 10
`define PWM_B_EVENT_BIT 9
`define CAN_TX_REQUEST_BIT 6
`define DMA_CHAN7_DONE_BIT 5
`define DMA_CHAN6_DONE_BIT 4
`define CHECKSUM_UNIT_BIT 3
`define SERIAL_B_ERROR_BIT 2
`define SERIAL_A_ERROR_BIT 1

// Masks of implemented bits, and the flag reset value.
`define FLAGS_TWO_IMPL 16'he600
`define FLAGS_THREE_IMPL 16'hce7e
`define FLAGS_RESET 16'h0000

// Bus responses.
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// file: verilog/flag_bank_pkg.sv
package flag_bank_pkg;
  typedef logic [15:0] flag_word_t;
endpackage : flag_bank_pkg

// file: dv/event_sources.sv
module event_sources (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic fire_in,
  input wire logic [3:0] index_in,
  input wire logic [3:0] delay_in,
  output logic [15:0] req_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_q;
  logic [3:0] count_q;
  logic [3:0] index_q;

  // Each source raises a single-cycle request after the commanded delay.
  always_ff @(posedge clk_in) begin
    req_out <= '0;
    if (sys_rst_in) begin
      busy_q <= 1'b0;
      count_q <= 4'h0;
    end else if (fire_in && !busy_q) begin
      busy_q <= 1'b1;
      count_q <= delay_in;
      index_q <= index_in;
    end else if (busy_q && count_q == 4'h0) begin
      req_out[index_q] <= 1'b1;
      busy_q <= 1'b0;
    end else if (busy_q) begin
      count_q <= count_q - 4'h1;
    end
  end
endmodule : event_sources

// file: dv/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import flag_bank_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic fire = 1'b0;
  logic [3:0] index = 4'h0;
  logic [3:0] delay = 4'h0;
  logic [15:0] req;
  logic pwm_a_fault_in, calendar_clock_in, dma_chan5_done_in;
  logic encoder_a_event_in, pwm_a_event_in, audio_left_in, audio_right_in;
  logic encoder_b_event_in, pwm_b_fault_in, pwm_b_event_in;
  logic can_transmit_request_in, dma_chan7_done_in, dma_chan6_done_in;
  logic checksum_unit_in, serial_b_error_in, serial_a_error_in;
  logic [3:0] s_axi_awaddr_in = 4'h0;
  logic [3:0] s_axi_araddr_in = 4'h0;
  logic [31:0] s_axi_wdata_in = 32'h0;
  logic [3:0] s_axi_wstrb_in = 4'h3;
  logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
  logic s_axi_bready_in = 1'b0, s_axi_arvalid_in = 1'b0;
  logic s_axi_rready_in = 1'b0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic s_axi_arready_out, s_axi_rvalid_out, irq_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rs;
  logic [31:0] s_axi_rdata_out, rd;
  flag_word_t interrupt_flags_two_out, interrupt_flags_three_out;
  flag_word_t nocan_three;
  int failures = 0;
  int compares = 0;
  int pos [16] = '{15, 14, 13, 10, 9, 15, 14, 11, 10, 9, 6, 5, 4, 3, 2, 1};

  always #2 clk_in = ~clk_in;
  assign {serial_a_error_in, serial_b_error_in, checksum_unit_in,
    dma_chan6_done_in, dma_chan7_done_in, can_transmit_request_in,
    pwm_b_event_in, pwm_b_fault_in, encoder_b_event_in, audio_right_in,
    audio_left_in, pwm_a_event_in, encoder_a_event_in, dma_chan5_done_in,
    calendar_clock_in, pwm_a_fault_in} = req;

  event_sources i_src (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .fire_in(fire), .index_in(index), .delay_in(delay), .req_out(req));
  interrupt_flag_status_bank i_dut (.*);
  interrupt_flag_status_bank #(.CAN_PRESENT(1'b0)) i_nocan (.*,
    .s_axi_awready_out(), .s_axi_wready_out(), .s_axi_bresp_out(),
    .s_axi_bvalid_out(), .s_axi_arready_out(), .s_axi_rdata_out(),
    .s_axi_rresp_out(), .s_axi_rvalid_out(), .interrupt_flags_two_out(),
    .interrupt_flags_three_out(nocan_three), .irq_out());

  task automatic end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    bit done;
    done = 1'b0;
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge clk_in);
      if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      if (s_axi_bvalid_out) begin
        r = s_axi_bresp_out;
        s_axi_bready_in <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) begin
      failures++;
      end_sim;
    end
  endtask : axi_write

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    bit done;
    done = 1'b0;
    @(posedge clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge clk_in);
      if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      if (s_axi_rvalid_out) begin
        d = s_axi_rdata_out;
        r = s_axi_rresp_out;
        s_axi_rready_in <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) begin
      failures++;
      end_sim;
    end
  endtask : axi_read

  // Commands one source, then waits until the flag copy has settled.
  task automatic ev(input int i, input int dly);
    @(posedge clk_in);
    fire <= 1'b1;
    index <= 4'(i);
    delay <= 4'(dly);
    @(posedge clk_in);
    fire <= 1'b0;
    repeat (dly + 5) @(posedge clk_in);
  endtask : ev

  initial begin
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    for (int a = 0; a < 16; a += 4) begin
      axi_read(4'(a), rd, rs);
      check(rd, 32'h0);
      check({30'h0, rs}, 32'h0);
    end
    check({31'h0, irq_out}, 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 16; i++) begin
      ev(i, i % 4);
      axi_read(i < 5 ? 4'h0 : 4'h4, rd, rs);
      check(rd, 32'h1 << pos[i]);
      check({16'h0, i < 5 ? interrupt_flags_two_out :
             interrupt_flags_three_out}, 32'h1 << pos[i]);
      if (i == 10) check({16'h0, nocan_three}, 32'h0);
      axi_write(i < 5 ? 4'h0 : 4'h4, 32'h0, rs);
      check({30'h0, rs}, 32'h0);
      axi_read(i < 5 ? 4'h0 : 4'h4, rd, rs);
      check(rd, 32'h0);
    end
    $display("test flag positions done");
    axi_write(4'h0, 32'hffffffff, rs);
    check({30'h0, rs}, 32'h0);
    axi_write(4'h4, 32'hffffffff, rs);
    axi_read(4'h0, rd, rs);
    check(rd, 32'h0000e600);
    axi_read(4'h4, rd, rs);
    check(rd, 32'h0000ce7e);
    check({16'h0, nocan_three}, 32'h0000ce3e);
    $display("test unimplemented bits done");
    axi_write(4'h8, 32'h0000ffff, rs);
    repeat (3) @(posedge clk_in);
    check({31'h0, irq_out}, 32'h1);
    axi_write(4'h0, 32'h0, rs);
    repeat (3) @(posedge clk_in);
    check({31'h0, irq_out}, 32'h0);
    axi_write(4'hc, 32'h00000002, rs);
    repeat (3) @(posedge clk_in);
    check({31'h0, irq_out}, 32'h1);
    axi_write(4'h4, 32'h0, rs);
    axi_write(4'h8, 32'h0, rs);
    ev(0, 2);
    check({31'h0, irq_out}, 32'h0);
    $display("test interrupt output done");
    axi_read(4'h2, rd, rs);
    check({rs, rd[29:0]}, 32'h80000000);
    axi_write(4'h2, 32'hffffffff, rs);
    check({30'h0, rs}, 32'h2);
    $display("test unmapped access done");
    end_sim;
  end
endmodule : tb
